/* hw/stx_pkg.sv */
package stx_pkg;
    // ----------------------------------------
    // Bus and register map
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] ADDR_FORMAT = 3'h0;
    localparam logic [2:0] ADDR_DIVISOR = 3'h1;
    localparam logic [2:0] ADDR_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_HOLD = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam logic [2:0] ADDR_RXDATA = 3'h5;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FMT_SYNC_BIT = 7;
    localparam int FMT_CHR7_BIT = 6;
    localparam int FMT_PAR_EN_BIT = 5;
    localparam int FMT_PAR_ODD_BIT = 4;
    localparam int FMT_STOP2_BIT = 3;
    localparam int FMT_MP_BIT = 2;
    localparam int FMT_CKS_HI = 1;
    localparam int FMT_CKS_LO = 0;
    localparam int CTL_TX_EN_BIT = 5;
    localparam int CTL_RX_EN_BIT = 4;
    localparam int ST_TX_EMPTY_BIT = 7;
    localparam int ST_RX_AVAIL_BIT = 6;
    localparam int ST_OVERRUN_BIT = 5;
    localparam int ST_FRAME_BIT = 4;
    localparam int ST_PARITY_BIT = 3;
    localparam int ST_TX_END_BIT = 2;
    localparam int ST_MP_TX_BIT = 0;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] FORMAT_RST = 8'h00;
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] HOLD_RST = 8'hFF;
    localparam logic TX_EMPTY_RST = 1'b1;
    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam logic [5:0] PRE_LIM_0 = 6'h00;
    localparam logic [5:0] PRE_LIM_1 = 6'h03;
    localparam logic [5:0] PRE_LIM_2 = 6'h0F;
    localparam logic [5:0] PRE_LIM_3 = 6'h3F;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_HALF = 4'h7;
    localparam logic [2:0] LAST_BIT_8 = 3'h7;
    localparam logic [2:0] LAST_BIT_7 = 3'h6;
    // ----------------------------------------
    // State types
    // ----------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP1, TX_STOP2} stx_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} stx_rx_state_t;
endpackage

/* hw/stx_serial_unit.sv */
// Behaviour
// RULE1: Shift register sends least significant bit first
// RULE2: Empty shift register loads holding byte, starts
// RULE3: Pending byte follows previous frame without gap
// RULE4: Shift register is not software visible
// RULE5: Holding register eight bits, resets to FF
// RULE6: Software writes holding once per empty flag
// RULE7: Format bit 7 selects asynchronous or clocked
// RULE8: Format bit 6 selects seven data bits
// RULE9: Format bit 5 adds and checks parity
// RULE10: Format bit 4 selects odd parity
// RULE11: Format bit 3 selects two stop bits
// RULE12: Receiver checks only the first stop bit
// RULE13: Low bit after stop starts next character
// RULE14: Multiprocessor bit 2 overrides parity settings
// RULE15: Software keeps multiprocessor off in clocked mode
// RULE16: Format bits 1:0 pick prescale 1/4/16/64
// RULE17: Transmit only while transmit enable is set
// RULE18: Empty flag sets on transfer, clears on write
// RULE19: Idle line high, frame starts low
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module stx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic push;
    logic pop;
    assign o_in_ready = (count_ff != DEPTH[PW:0]);
    assign o_out_valid = (count_ff != '0);
    assign o_out_data = mem_ff[rd_ptr_ff];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

module stx_serial_unit (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [stx_pkg::ADDR_W-1:0] i_addr,
    input wire logic [stx_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [stx_pkg::DATA_W-1:0] o_rdata,
    output logic o_txd,
    input wire logic i_rxd,
    output logic o_sck,
    output logic o_sck_oe
);
    import stx_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic par_of(input logic [7:0] d, input logic chr7, input logic odd);
        par_of = (^(chr7 ? (d & 8'h7F) : d)) ^ odd;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] fmt_ff;
    logic [7:0] div_ff;
    logic [7:0] ctl_ff;
    logic [7:0] hold_ff;
    logic tx_empty_ff;
    logic mp_tx_ff;
    logic ovr_ff;
    logic ferr_ff;
    logic perr_ff;
    logic [7:0] rdata_ff;
    stx_tx_state_t tx_state_ff;
    logic [7:0] tx_shift_ff;
    logic [2:0] tx_cnt_ff;
    logic [3:0] tx_os_ff;
    logic tx_par_ff;
    logic txd_ff;
    logic sck_ff;
    logic sck_oe_ff;
    logic [5:0] pre_cnt_ff;
    logic pre_tick_ff;
    logic [7:0] div_cnt_ff;
    logic os_tick;
    logic rxd_s1_ff;
    logic rxd_s2_ff;
    logic rxd_prev_ff;
    stx_rx_state_t rx_state_ff;
    logic [3:0] rx_os_ff;
    logic [2:0] rx_cnt_ff;
    logic [7:0] rx_shift_ff;
    logic rx_extra_ff;
    logic [7:0] rx_hold_ff;
    logic rx_pend_ff;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;

    // ----------------------------------------
    // Decoded mode
    // ----------------------------------------
    logic mode_sync;
    logic chr7;
    logic mp_on;
    logic par_on;
    logic stop2;
    logic par_odd;
    logic tx_en;
    logic rx_en;
    logic wr_hold;
    logic wr_status;
    logic [7:0] rx_word;
    assign mode_sync = fmt_ff[FMT_SYNC_BIT]; // see RULE7
    assign chr7 = !mode_sync & fmt_ff[FMT_CHR7_BIT]; // see RULE8
    assign mp_on = !mode_sync & fmt_ff[FMT_MP_BIT];
    assign par_on = !mode_sync & fmt_ff[FMT_PAR_EN_BIT] & !mp_on; // see RULE9 see RULE14
    assign par_odd = fmt_ff[FMT_PAR_ODD_BIT]; // see RULE10
    assign stop2 = !mode_sync & fmt_ff[FMT_STOP2_BIT]; // see RULE11
    assign tx_en = ctl_ff[CTL_TX_EN_BIT];
    assign rx_en = ctl_ff[CTL_RX_EN_BIT] & !mode_sync;
    assign wr_hold = i_wr && (i_addr == ADDR_HOLD);
    assign wr_status = i_wr && (i_addr == ADDR_STATUS);
    assign fifo_pop = i_rd && (i_addr == ADDR_RXDATA);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fmt_ff <= FORMAT_RST;
            div_ff <= DIVISOR_RST;
            ctl_ff <= CONTROL_RST;
            hold_ff <= HOLD_RST; // see RULE5
            mp_tx_ff <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                ADDR_FORMAT: fmt_ff <= i_wdata;
                ADDR_DIVISOR: div_ff <= i_wdata;
                ADDR_CONTROL: ctl_ff <= i_wdata;
                ADDR_HOLD: hold_ff <= i_wdata;
                ADDR_STATUS: mp_tx_ff <= i_wdata[ST_MP_TX_BIT];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_ff <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_FORMAT: rdata_ff <= fmt_ff;
                ADDR_DIVISOR: rdata_ff <= div_ff;
                ADDR_CONTROL: rdata_ff <= ctl_ff;
                ADDR_HOLD: rdata_ff <= hold_ff; // see RULE4
                ADDR_STATUS: rdata_ff <= {tx_empty_ff, fifo_out_valid, ovr_ff, ferr_ff, perr_ff,
                                          (tx_state_ff == TX_IDLE) & tx_empty_ff, 1'b0, mp_tx_ff};
                ADDR_RXDATA: rdata_ff <= fifo_out_valid ? fifo_out_data : 8'h00;
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign o_rdata = rdata_ff;

    // ----------------------------------------
    // Baud clock
    // ----------------------------------------
    logic [5:0] pre_lim;
    always_comb begin
        case (fmt_ff[FMT_CKS_HI:FMT_CKS_LO])
            2'h0: pre_lim = PRE_LIM_0;
            2'h1: pre_lim = PRE_LIM_1;
            2'h2: pre_lim = PRE_LIM_2;
            default: pre_lim = PRE_LIM_3;
        endcase
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_cnt_ff <= 6'h00;
            pre_tick_ff <= 1'b0;
        end else if (pre_cnt_ff >= pre_lim) begin
            pre_cnt_ff <= 6'h00; // see RULE16
            pre_tick_ff <= 1'b1;
        end else begin
            pre_cnt_ff <= pre_cnt_ff + 6'h01;
            pre_tick_ff <= 1'b0;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_ff <= 8'h00;
        end else if (pre_tick_ff) begin
            div_cnt_ff <= (div_cnt_ff >= div_ff) ? 8'h00 : div_cnt_ff + 8'h01;
        end
    end
    assign os_tick = pre_tick_ff && (div_cnt_ff >= div_ff);

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    logic tx_bit_end;
    logic tx_last_data;
    logic tx_frame_last;
    logic tx_load;
    assign tx_bit_end = os_tick && (tx_os_ff == OS_LAST);
    assign tx_last_data = tx_cnt_ff == (chr7 ? LAST_BIT_7 : LAST_BIT_8);
    assign tx_frame_last = tx_bit_end && (((tx_state_ff == TX_STOP1) && !stop2) || (tx_state_ff == TX_STOP2)
                           || ((tx_state_ff == TX_DATA) && mode_sync && tx_last_data));
    assign tx_load = tx_en && !tx_empty_ff && !wr_hold && os_tick
                     && ((tx_state_ff == TX_IDLE) || tx_frame_last); // see RULE2 see RULE3

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_empty_ff <= TX_EMPTY_RST;
        end else if (tx_load) begin
            tx_empty_ff <= 1'b1; // see RULE18
        end else if (wr_hold) begin
            tx_empty_ff <= 1'b0; // see RULE18
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_state_ff <= TX_IDLE;
            tx_shift_ff <= 8'h00;
            tx_cnt_ff <= 3'h0;
            tx_os_ff <= 4'h0;
            tx_par_ff <= 1'b0;
        end else if (!tx_en) begin
            tx_state_ff <= TX_IDLE; // see RULE17
            tx_os_ff <= 4'h0;
        end else if (tx_load) begin
            tx_state_ff <= mode_sync ? TX_DATA : TX_START;
            tx_shift_ff <= hold_ff;
            tx_cnt_ff <= 3'h0;
            tx_os_ff <= 4'h0;
            tx_par_ff <= mp_on ? mp_tx_ff : par_of(hold_ff, chr7, par_odd); // see RULE10 see RULE14
        end else if (tx_state_ff != TX_IDLE) begin
            if (os_tick) begin
                tx_os_ff <= tx_os_ff + 4'h1;
            end
            if (tx_bit_end) begin
                case (tx_state_ff)
                    TX_START: tx_state_ff <= TX_DATA;
                    TX_DATA: begin
                        tx_shift_ff <= {1'b0, tx_shift_ff[7:1]}; // see RULE1
                        tx_cnt_ff <= tx_cnt_ff + 3'h1;
                        if (tx_last_data) begin
                            if (mode_sync) begin
                                tx_state_ff <= TX_IDLE;
                            end else if (par_on || mp_on) begin
                                tx_state_ff <= TX_EXTRA; // see RULE9
                            end else begin
                                tx_state_ff <= TX_STOP1;
                            end
                        end
                    end
                    TX_EXTRA: tx_state_ff <= TX_STOP1;
                    TX_STOP1: tx_state_ff <= stop2 ? TX_STOP2 : TX_IDLE; // see RULE11
                    default: tx_state_ff <= TX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            txd_ff <= 1'b1;
            sck_ff <= 1'b1;
            sck_oe_ff <= 1'b0;
        end else begin
            case (tx_state_ff)
                TX_START: txd_ff <= 1'b0; // see RULE19
                TX_DATA: txd_ff <= tx_shift_ff[0]; // see RULE1
                TX_EXTRA: txd_ff <= tx_par_ff;
                default: txd_ff <= 1'b1; // see RULE19
            endcase
            sck_oe_ff <= mode_sync;
            sck_ff <= !((tx_state_ff == TX_DATA) && mode_sync && (tx_os_ff <= OS_HALF));
        end
    end
    assign o_txd = txd_ff;
    assign o_sck = sck_ff;
    assign o_sck_oe = sck_oe_ff;

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    logic rx_sample;
    logic rx_done;
    assign rx_sample = os_tick && (rx_os_ff == OS_LAST);
    assign rx_done = rx_sample && (rx_state_ff == RX_STOP);
    assign rx_word = chr7 ? {1'b0, rx_shift_ff[7:1]} : rx_shift_ff;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_prev_ff <= 1'b1;
        end else begin
            rxd_s1_ff <= i_rxd;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_prev_ff <= rxd_s2_ff;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_state_ff <= RX_IDLE;
            rx_os_ff <= 4'h0;
            rx_cnt_ff <= 3'h0;
            rx_shift_ff <= 8'h00;
            rx_extra_ff <= 1'b0;
        end else if (!rx_en) begin
            rx_state_ff <= RX_IDLE;
        end else begin
            if (os_tick) begin
                rx_os_ff <= rx_os_ff + 4'h1;
            end
            case (rx_state_ff)
                RX_IDLE: begin
                    if (rxd_prev_ff && !rxd_s2_ff) begin
                        rx_state_ff <= RX_START; // see RULE13
                        rx_os_ff <= 4'h0;
                    end
                end
                RX_START: begin
                    if (os_tick && (rx_os_ff == OS_HALF)) begin
                        rx_state_ff <= rxd_s2_ff ? RX_IDLE : RX_DATA;
                        rx_os_ff <= 4'h0;
                        rx_cnt_ff <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_ff <= {rxd_s2_ff, rx_shift_ff[7:1]};
                        rx_cnt_ff <= rx_cnt_ff + 3'h1;
                        if (rx_cnt_ff == (chr7 ? LAST_BIT_7 : LAST_BIT_8)) begin
                            rx_state_ff <= (par_on || mp_on) ? RX_EXTRA : RX_STOP;
                        end
                    end
                end
                RX_EXTRA: begin
                    if (rx_sample) begin
                        rx_extra_ff <= rxd_s2_ff;
                        rx_state_ff <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_state_ff <= RX_IDLE; // see RULE12
                    end
                end
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_hold_ff <= 8'h00;
            rx_pend_ff <= 1'b0;
        end else if (rx_done && (!rx_pend_ff || fifo_in_ready)) begin
            rx_hold_ff <= rx_word;
            rx_pend_ff <= 1'b1;
        end else if (fifo_in_ready) begin
            rx_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ovr_ff <= 1'b0;
            ferr_ff <= 1'b0;
            perr_ff <= 1'b0;
        end else begin
            if (rx_done && rx_pend_ff && !fifo_in_ready) begin
                ovr_ff <= 1'b1;
            end else if (wr_status && !i_wdata[ST_OVERRUN_BIT]) begin
                ovr_ff <= 1'b0;
            end
            if (rx_done && !rxd_s2_ff) begin
                ferr_ff <= 1'b1; // see RULE12
            end else if (wr_status && !i_wdata[ST_FRAME_BIT]) begin
                ferr_ff <= 1'b0;
            end
            if (rx_done && par_on && (rx_extra_ff != par_of(rx_word, chr7, par_odd))) begin
                perr_ff <= 1'b1; // see RULE9 see RULE10
            end else if (wr_status && !i_wdata[ST_PARITY_BIT]) begin
                perr_ff <= 1'b0;
            end
        end
    end

    stx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_in_valid(rx_pend_ff),
        .o_in_ready(fifo_in_ready),
        .i_in_data(rx_hold_ff),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_empty_on_write: assert property (wr_hold |=> !tx_empty_ff) // see RULE18
        else $error("empty flag not cleared by write");
    a_load_moves_byte: assert property (tx_load |=> tx_empty_ff && tx_shift_ff == $past(hold_ff)) // see RULE2
        else $error("holding byte not moved");
    a_lsb_first: assert property ((tx_state_ff == TX_DATA) |=> o_txd == $past(tx_shift_ff[0])) // see RULE1
        else $error("data bit order wrong");
    a_idle_high: assert property ((tx_state_ff == TX_IDLE) |=> o_txd) // see RULE19
        else $error("idle line not high");
    a_start_low: assert property ((tx_state_ff == TX_START) |=> !o_txd) // see RULE19
        else $error("start bit not low");
    a_no_gap: assert property (tx_frame_last && tx_load |=> tx_state_ff != TX_IDLE) // see RULE3
        else $error("gap between frames");
    a_tx_gated: assert property (!tx_en |=> tx_state_ff == TX_IDLE) // see RULE17
        else $error("sending while disabled");
    a_parity_sense: assert property (tx_load && par_on |=> tx_par_ff == ((^$past(chr7 ? (hold_ff & 8'h7F) : hold_ff))
        ^ $past(par_odd))) // see RULE10
        else $error("parity bit wrong");
    a_stop_length: assert property (tx_bit_end && (tx_state_ff == TX_STOP1) && stop2 && tx_en
        |=> tx_state_ff == TX_STOP2) // see RULE11
        else $error("second stop bit missing");
    a_char_length: assert property (tx_bit_end && (tx_state_ff == TX_DATA) && chr7 && tx_cnt_ff == 3'h6 && tx_en
        && !mode_sync |=> tx_state_ff != TX_DATA) // see RULE8
        else $error("seven bit length ignored");
    a_one_stop_rx: assert property (rx_done && rx_en |=> rx_state_ff == RX_IDLE) // see RULE12
        else $error("receiver checks more stop bits");
    a_prescale_gap: assert property (pre_tick_ff && fmt_ff[1:0] == 2'h1 |=> !pre_tick_ff [*3]) // see RULE16
        else $error("prescale divide wrong");
    c_back_to_back: cover property (tx_frame_last && tx_load);
    c_rx_frame: cover property (rx_done);
    c_sync_frame: cover property (mode_sync && tx_load);
    c_overrun: cover property (rx_done && rx_pend_ff && !fifo_in_ready);
endmodule

/* test/stx_peer.sv */
`timescale 1ns/100ps
// ------
// Remote station: samples each frame at mid-bit
// ------
module stx_peer (
    input wire logic i_clock,
    input wire logic i_txd,
    input wire logic i_sck,
    input wire logic [11:0] i_bit_clks,
    input wire logic [3:0] i_nbits,
    output logic o_rxd
);
    logic [10:0] rx_q[$];
    longint start_q[$];
    logic [10:0] shape;
    logic [7:0] sync_word = '0;
    int sync_cnt = 0;
    // Station echoes the line back to the receiver
    assign o_rxd = i_txd;
    // Clocked mode: capture data on each rising clock edge
    always @(posedge i_sck) begin
        sync_word = {i_txd, sync_word[7:1]};
        sync_cnt++;
    end
    initial begin
        forever begin
            @(negedge i_txd);
            start_q.push_back($time);
            shape = '0;
            repeat (i_bit_clks / 2) @(posedge i_clock);
            for (int i = 0; i < i_nbits; i++) begin
                shape[i] = i_txd;
                if (i < i_nbits - 1) repeat (i_bit_clks) @(posedge i_clock);
            end
            rx_q.push_back(shape);
        end
    end
endmodule

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
    import stx_pkg::*;
    logic i_clock, i_rst_b, i_wr, i_rd, i_rxd, o_txd, o_sck, o_sck_oe;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, s, f, d0, d1;
    logic [11:0] bclk;
    logic [3:0] nb;
    logic [7:0] fmts [10] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h70, 8'h08, 8'h74, 8'h01, 8'h02, 8'h03};
    int err_count = 0;
    int check_count = 0;
    int n0;
    stx_serial_unit u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_txd(o_txd), .i_rxd(i_rxd), .o_sck(o_sck),
        .o_sck_oe(o_sck_oe));
    stx_peer u_peer (.i_clock(i_clock), .i_txd(o_txd), .i_sck(o_sck), .i_bit_clks(bclk), .i_nbits(nb),
        .o_rxd(i_rxd));
    // ------
    // Helpers
    // ------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clock);
    endtask
    task automatic wait_st(input int b);
        for (int k = 0; k < 15000; k++) begin
            rd(ADDR_STATUS, s);
            if (s[b] === 1'b1) return;
        end
        check(16'h0, 16'h1);
        give_verdict();
    endtask
    function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic [7:0] fm);
        logic [10:0] v;
        logic p;
        int db;
        v = '0;
        db = fm[6] ? 7 : 8;
        p = fm[4];
        for (int i = 0; i < db; i++) begin
            v[i + 1] = d[i];
            p = p ^ d[i];
        end
        if (fm[2] | fm[5]) begin
            v[db + 1] = fm[2] ? 1'b1 : p;
            db++;
        end
        v[db + 1] = 1'b1;
        return v;
    endfunction
    // ------
    // Stimulus
    // ------
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial begin
        i_rst_b = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        bclk = 12'h010;
        nb = 4'hA;
        void'($urandom(32'hD34B));
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        #1 check(o_txd, 1'b1);
        check(o_sck_oe, 1'b0);
        rd(ADDR_FORMAT, s);
        check(s, 8'h00);
        rd(ADDR_HOLD, s);
        check(s, 8'hFF);
        rd(ADDR_STATUS, s);
        check(s, 8'h84);
        rd(3'h7, s);
        check(s, 8'h00);
        $display("reset test done");
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_HOLD, 8'h5A);
        rd(ADDR_STATUS, s);
        check(s, 8'h01);
        repeat (64) @(posedge i_clock);
        check(16'(u_peer.start_q.size()), 16'h0);
        wr(ADDR_CONTROL, 8'h30);
        wait_st(ST_TX_END_BIT);
        check(u_peer.rx_q.pop_front(), exp_frame(8'h5A, 8'h00));
        wait_st(ST_RX_AVAIL_BIT);
        rd(ADDR_RXDATA, s);
        check(s, 8'h5A);
        u_peer.start_q.delete();
        $display("enable test done");
        foreach (fmts[j]) begin
            f = fmts[j];
            d0 = (j == 1) ? 8'hFF : 8'($urandom);
            d1 = 8'($urandom);
            bclk = 12'h010 << (2 * f[1:0]);
            nb = (f[6] ? 4'h9 : 4'hA) + ((f[5] | f[2]) ? 4'h1 : 4'h0);
            wr(ADDR_FORMAT, f);
            rd(ADDR_FORMAT, s);
            check(s, f);
            wr(ADDR_HOLD, d0);
            wait_st(ST_TX_EMPTY_BIT);
            wr(ADDR_HOLD, d1);
            wait_st(ST_TX_END_BIT);
            check(16'(u_peer.rx_q.size()), 16'h2);
            check(u_peer.rx_q.pop_front(), exp_frame(d0, f));
            check(u_peer.rx_q.pop_front(), exp_frame(d1, f));
            check(16'(u_peer.start_q[1] - u_peer.start_q[0]), 16'(5 * bclk * (nb + f[3])));
            wait_st(ST_RX_AVAIL_BIT);
            rd(ADDR_RXDATA, s);
            check(s, d0 & (f[6] ? 8'h7F : 8'hFF));
            wait_st(ST_RX_AVAIL_BIT);
            rd(ADDR_RXDATA, s);
            check(s, d1 & (f[6] ? 8'h7F : 8'hFF));
            rd(ADDR_STATUS, s);
            check(s[5:3], 3'h0);
            u_peer.start_q.delete();
            $display("format %h test done", f);
        end
        wr(ADDR_FORMAT, 8'h80);
        n0 = u_peer.sync_cnt;
        wr(ADDR_HOLD, d1);
        wait_st(ST_TX_END_BIT);
        check(o_sck_oe, 1'b1);
        check(16'(u_peer.sync_cnt - n0), 16'h8);
        check(u_peer.sync_word, d1);
        check(o_sck, 1'b1);
        $display("clocked mode test done");
        give_verdict();
    end
endmodule
